// ===== core/qbsc_cfg.svh
/*
  constants of the burst-of-four memory command port: widths, beat timing, drain count.
  assumes it is included by its bare name from package and modules.
*/
`ifndef QBSC_CFG_SVH
`define QBSC_CFG_SVH

// ************************************************************
// organisation
// ************************************************************
`define QBSC_DW 18
`define QBSC_AW 22
`define QBSC_LANES 2
`define QBSC_LANE_W 9
`define QBSC_BEATS 4
`define QBSC_SLOTS 2

// ************************************************************
// beat timing, in half-cycle edges after the command edge
// ************************************************************
`define QBSC_RD_FIRST 3
`define QBSC_WR_FIRST 4
`define QBSC_DRAIN 4'h8
`define QBSC_LAST_BEAT 2'h3

`endif

// ===== core/qbsc_pkg.sv
/*
  types shared by both ends of the burst-of-four memory command port.
  assumes qbsc_cfg.svh is on the include path.
*/
`include "qbsc_cfg.svh"

package qbsc_pkg;

  // ************************************************************
  // data and control types
  // ************************************************************
  typedef logic [`QBSC_DW-1:0] qbsc_word_type;
  typedef logic [`QBSC_LANES-1:0] qbsc_mask_type;
  typedef logic [1:0] qbsc_beat_type;
  typedef qbsc_word_type [`QBSC_BEATS-1:0] qbsc_burst_type;
  typedef qbsc_mask_type [`QBSC_BEATS-1:0] qbsc_burst_mask_type;

  // controller clock states
  typedef enum logic [1:0] {
    QBSC_RUN = 2'h0,
    QBSC_DRAINING = 2'h1,
    QBSC_STOPPED = 2'h2
  } qbsc_clk_state_type;

endpackage

// ===== core/qbsc_if.sv
/*
  link between the memory end and the controller end.
  assumes both ends run on the same sys_clk; k and c pairs are sampled levels.
*/
`timescale 1ns/100ps
`include "qbsc_cfg.svh"

interface qbsc_if #(parameter int AW = `QBSC_AW);
  import qbsc_pkg::*;

  logic k_clk; // input timing clock level, k# is its inverse
  logic c_clk; // output strobe, positive
  logic c_n_clk; // output strobe, negative
  logic rd_sel_n; // read select, low active
  logic wr_sel_n; // write select, low active
  logic [AW-1:0] addr; // burst start address
  qbsc_word_type d; // write data beat
  qbsc_mask_type byte_mask_n; // byte_mask_lane1_n, byte_mask_lane0_n
  qbsc_word_type q; // read data beat
  logic q_valid; // q was updated this cycle

  modport mem (input k_clk, c_clk, c_n_clk, rd_sel_n, wr_sel_n, addr, d, byte_mask_n,
               output q, q_valid);
  modport ctl (output k_clk, c_clk, c_n_clk, rd_sel_n, wr_sel_n, addr, d, byte_mask_n,
               input q, q_valid);
endinterface

// ===== core/qbsc_burst_seq.sv
/*
  beat sequencer: shifts command starts along half-cycle edges and names the beat
  due at the current edge. assumes starts are at least four edges apart.
*/
`timescale 1ns/100ps
`include "qbsc_cfg.svh"

module qbsc_burst_seq #(
  parameter int TW = 1,
  parameter int FIRST = `QBSC_RD_FIRST
) (
  input wire logic sys_clk, // system clock
  input wire logic rst, // async reset, high
  input wire logic ce, // clock enable
  input wire logic edge_hit, // a half-cycle edge happens now
  input wire logic start, // command taken at this edge
  input wire logic [TW-1:0] tag, // carried with the command
  output logic beat_go, // a beat is due at this edge
  output qbsc_pkg::qbsc_beat_type beat_idx, // which beat of four
  output logic [TW-1:0] beat_tag // tag of that burst
);
  import qbsc_pkg::*;

  localparam int LAST = FIRST + `QBSC_BEATS - 1;

  logic [LAST-1:0] stage_v;
  logic [LAST-1:0][TW-1:0] stage_t;
  logic [LAST-1:0] next_stage_v;
  logic [LAST-1:0][TW-1:0] next_stage_t;

  // ************************************************************
  // pipeline of pending starts
  // ************************************************************
  // fixed four beats
  always_comb begin
    next_stage_v = stage_v;
    next_stage_t = stage_t;
    beat_go = 1'b0;
    beat_idx = 2'h0;
    beat_tag = '0;
    for (int i = 0; i < `QBSC_BEATS; i++) begin
      if (edge_hit && stage_v[FIRST-1+i]) begin
        beat_go = 1'b1;
        beat_idx = 2'(i);
        beat_tag = stage_t[FIRST-1+i];
      end
    end
    if (edge_hit) begin
      next_stage_v = {stage_v[LAST-2:0], start};
      next_stage_t = {stage_t[LAST-2:0], tag};
    end
  end

  // frozen while no edge arrives, so a stopped clock keeps bursts intact
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stage_v <= '0;
      stage_t <= '0;
    end else if (ce) begin
      stage_v <= next_stage_v;
      stage_t <= next_stage_t;
    end
  end
endmodule

// ===== core/qbsc_mem_end.sv
/*
  memory end: command acceptance, spacing, priority, write buffers, array, read beats.
  assumes the controller end drives the link from the same sys_clk; one sys_clk cycle
  is one half of the input timing clock.
*/
//
// Summary of operation
// - read starts on low read select
// - write starts on low write select
// - every burst is exactly four beats
// - same commands at most every second k rise
// - back-to-back same command: second dropped
// - both selects after idle: read only
// - drain bursts before stopping clocks; state held
// - read beats at 1.5, 2, 2.5, 3
// - write beats at 2, 2.5, 3, 3.5
// - lane masks per beat, both high aborts
// - masks apply only to accepted writes
// - idle cycle never cuts a read short
// - burst addresses advance linearly by one
// - two newest writes served from buffers
// - strobes tied high: k pair times reads
`timescale 1ns/100ps
`include "qbsc_cfg.svh"

module qbsc_mem_end #(
  parameter int AW = `QBSC_AW
) (
  input wire logic sys_clk, // system clock
  input wire logic rst, // async reset, high
  input wire logic ce, // clock enable, freezes all state
  qbsc_if.mem link, // link to the controller
  output logic single_clk_mode, // strobe pair held high since reset
  output logic rd_dropped, // a read was discarded, pulse
  output logic wr_dropped // a write was discarded, pulse
);
  import qbsc_pkg::*;

  localparam int TW = AW + 1;

  // ************************************************************
  // declarations
  // ************************************************************
  logic k_prev;
  logic prev_rd;
  logic prev_wr;
  logic prev_idle;
  logic wr_tag;
  logic next_single;
  logic next_prev_rd;
  logic next_prev_wr;
  logic next_prev_idle;
  logic next_wr_tag;
  logic k_rise;
  logic k_edge;
  logic rd_go;
  logic wr_go;
  logic next_rd_dropped;
  logic next_wr_dropped;
  logic rd_beat;
  qbsc_beat_type rd_idx;
  logic [TW-1:0] rd_tag;
  logic wr_beat;
  qbsc_beat_type wr_idx;
  logic [TW-1:0] wr_btag;
  logic [AW-1:0] rd_word_addr;
  qbsc_word_type next_q;
  logic next_q_valid;

  qbsc_word_type mem [0:(1<<AW)-1];
  logic [`QBSC_SLOTS-1:0] wb_valid;
  logic [`QBSC_SLOTS-1:0] wb_tag;
  logic [`QBSC_SLOTS-1:0][AW-1:0] wb_base;
  qbsc_burst_type [`QBSC_SLOTS-1:0] wb_data;
  qbsc_burst_mask_type [`QBSC_SLOTS-1:0] wb_en;
  logic [`QBSC_SLOTS-1:0] next_wb_valid;
  logic [`QBSC_SLOTS-1:0] next_wb_tag;
  logic [`QBSC_SLOTS-1:0][AW-1:0] next_wb_base;
  qbsc_burst_type [`QBSC_SLOTS-1:0] next_wb_data;
  qbsc_burst_mask_type [`QBSC_SLOTS-1:0] next_wb_en;

  // overlay enabled lanes of a buffered beat onto a word
  function automatic qbsc_word_type lane_merge(input qbsc_word_type base_w,
                                               input qbsc_word_type new_w,
                                               input qbsc_mask_type en);
    qbsc_word_type res;
    res = base_w;
    for (int l = 0; l < `QBSC_LANES; l++) begin
      if (en[l]) begin
        res[l*`QBSC_LANE_W +: `QBSC_LANE_W] = new_w[l*`QBSC_LANE_W +: `QBSC_LANE_W];
      end
    end
    return res;
  endfunction

  // ************************************************************
  // edge detection and command acceptance
  // ************************************************************
  // any toggle of k is a k or k# rising edge; a stopped clock gives none
  assign k_rise = link.k_clk & ~k_prev;
  assign k_edge = link.k_clk ^ k_prev;

  always_comb begin
    // second read on next k rise dropped
    rd_go = k_rise & ~link.rd_sel_n & ~prev_rd;
    // read wins after an idle cycle
    wr_go = k_rise & ~link.wr_sel_n & ~prev_wr & ~(prev_idle & ~link.rd_sel_n);
    next_rd_dropped = k_rise & ~link.rd_sel_n & prev_rd;
    next_wr_dropped = k_rise & ~link.wr_sel_n & ~wr_go;
    next_prev_rd = prev_rd;
    next_prev_wr = prev_wr;
    next_prev_idle = prev_idle;
    next_wr_tag = wr_go ? ~wr_tag : wr_tag;
    if (k_rise) begin
      next_prev_rd = rd_go;
      next_prev_wr = wr_go;
      next_prev_idle = link.rd_sel_n & link.wr_sel_n;
    end
    // any low on the strobe pair leaves single-clock mode for good
    next_single = single_clk_mode & link.c_clk & link.c_n_clk;
  end

  // ce low or a held k freezes every command flag
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      k_prev <= 1'b0;
      prev_rd <= 1'b0;
      prev_wr <= 1'b0;
      prev_idle <= 1'b1;
      wr_tag <= 1'b0;
      single_clk_mode <= 1'b1;
      rd_dropped <= 1'b0;
      wr_dropped <= 1'b0;
    end else if (ce) begin
      k_prev <= link.k_clk;
      prev_rd <= next_prev_rd;
      prev_wr <= next_prev_wr;
      prev_idle <= next_prev_idle;
      wr_tag <= next_wr_tag;
      single_clk_mode <= next_single;
      rd_dropped <= next_rd_dropped;
      wr_dropped <= next_wr_dropped;
    end
  end

  // ************************************************************
  // beat sequencers
  // ************************************************************
  // address rides with the command edge
  // idle cycles do not disturb the pipeline
  qbsc_burst_seq #(.TW(TW), .FIRST(`QBSC_RD_FIRST)) u_rd_seq (
    .sys_clk(sys_clk),
    .rst(rst),
    .ce(ce),
    .edge_hit(k_edge),
    .start(rd_go),
    .tag({1'b0, link.addr}),
    .beat_go(rd_beat),
    .beat_idx(rd_idx),
    .beat_tag(rd_tag)
  );

  qbsc_burst_seq #(.TW(TW), .FIRST(`QBSC_WR_FIRST)) u_wr_seq (
    .sys_clk(sys_clk),
    .rst(rst),
    .ce(ce),
    .edge_hit(k_edge),
    .start(wr_go),
    .tag({wr_tag, link.addr}),
    .beat_go(wr_beat),
    .beat_idx(wr_idx),
    .beat_tag(wr_btag)
  );

  // ************************************************************
  // write buffers
  // ************************************************************
  always_comb begin
    next_wb_valid = wb_valid;
    next_wb_tag = wb_tag;
    next_wb_base = wb_base;
    next_wb_data = wb_data;
    next_wb_en = wb_en;
    // newest write into slot 0, older one moves to slot 1
    if (wr_go) begin
      next_wb_valid = {wb_valid[0], 1'b1};
      next_wb_tag = {wb_tag[0], wr_tag};
      next_wb_base = {wb_base[0], link.addr};
      next_wb_data = {wb_data[0], qbsc_burst_type'('0)};
      next_wb_en = {wb_en[0], qbsc_burst_mask_type'('0)};
    end
    // beat lands in the slot of its own burst
    // only bursts that were accepted get beats
    for (int s = 0; s < `QBSC_SLOTS; s++) begin
      if (wr_beat && next_wb_valid[s] && next_wb_tag[s] == wr_btag[TW-1]) begin
        next_wb_data[s][wr_idx] = link.d;
        next_wb_en[s][wr_idx] = ~link.byte_mask_n;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wb_valid <= '0;
      wb_tag <= '0;
      wb_base <= '0;
      wb_data <= '0;
      wb_en <= '0;
    end else if (ce) begin
      wb_valid <= next_wb_valid;
      wb_tag <= next_wb_tag;
      wb_base <= next_wb_base;
      wb_data <= next_wb_data;
      wb_en <= next_wb_en;
    end
  end

  // array takes the oldest burst only when a third write pushes it out
  always_ff @(posedge sys_clk) begin
    if (ce && wr_go && wb_valid[1]) begin
      for (int b = 0; b < `QBSC_BEATS; b++) begin
        mem[wb_base[1] + AW'(b)] <= lane_merge(mem[wb_base[1] + AW'(b)], wb_data[1][b],
                                               wb_en[1][b]);
      end
    end
  end

  // ************************************************************
  // read beats
  // ************************************************************
  always_comb begin
    rd_word_addr = rd_tag[AW-1:0] + AW'(rd_idx);
    next_q = mem[rd_word_addr];
    for (int s = `QBSC_SLOTS - 1; s >= 0; s--) begin
      if (wb_valid[s] && (rd_word_addr - wb_base[s]) < AW'(`QBSC_BEATS)) begin
        next_q = lane_merge(next_q, wb_data[s][2'(rd_word_addr - wb_base[s])],
                            wb_en[s][2'(rd_word_addr - wb_base[s])]);
      end
    end
    next_q_valid = rd_beat;
  end

  // q updates on edges three to six after the read
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      link.q <= '0;
      link.q_valid <= 1'b0;
    end else if (ce) begin
      if (rd_beat) begin
        link.q <= next_q;
      end
      link.q_valid <= next_q_valid;
    end
  end
endmodule

// ===== core/qbsc_ctl_end.sv
/*
  controller end: makes the k and c pairs, issues spaced commands, sends write beats,
  collects read beats, and stops the clock only once bursts have drained.
  assumes user holds a request until its taken pulse.
*/
`timescale 1ns/100ps
`include "qbsc_cfg.svh"

module qbsc_ctl_end #(
  parameter int AW = `QBSC_AW,
  parameter bit SINGLE_CLK = 1'b0
) (
  input wire logic sys_clk, // system clock
  input wire logic rst, // async reset, high
  input wire logic ce, // clock enable, freezes all state
  qbsc_if.ctl link, // link to the memory
  input wire logic rd_req, // read wanted
  input wire logic [AW-1:0] rd_addr, // read start address
  input wire logic wr_req, // write wanted
  input wire logic [AW-1:0] wr_addr, // write start address
  input wire qbsc_pkg::qbsc_burst_type wr_data, // four write beats
  input wire qbsc_pkg::qbsc_burst_mask_type wr_mask_n, // lane masks per beat
  input wire logic stop_req, // ask to stop the clocks
  output logic rd_taken, // read issued, pulse
  output logic wr_taken, // write issued, pulse
  output qbsc_pkg::qbsc_word_type rd_data, // read beat
  output logic rd_valid, // rd_data new, pulse
  output logic stopped // clocks are held
);
  import qbsc_pkg::*;

  qbsc_clk_state_type state;
  qbsc_clk_state_type next_state;
  logic [3:0] quiet;
  logic [3:0] next_quiet;
  logic last_rd;
  logic last_wr;
  logic last_idle;
  logic next_last_rd;
  logic next_last_wr;
  logic next_last_idle;
  logic slot;
  logic toggling;
  logic rising;
  logic issue_rd;
  logic issue_wr;
  logic beat_go;
  qbsc_beat_type beat_idx;
  logic beat_slot;
  qbsc_burst_type [1:0] dbuf;
  qbsc_burst_mask_type [1:0] mbuf;

  // ************************************************************
  // clock and command decisions
  // ************************************************************
  assign toggling = (state != QBSC_STOPPED);
  assign rising = toggling & ~link.k_clk;

  always_comb begin
    next_state = state;
    next_quiet = quiet;
    // never the same command on two k rises in a row
    issue_rd = rising && state == QBSC_RUN && rd_req && !last_rd;
    // skip a write that would lose to a read after idle
    issue_wr = rising && state == QBSC_RUN && wr_req && !last_wr && !(last_idle && issue_rd);
    next_last_rd = rising ? issue_rd : last_rd;
    next_last_wr = rising ? issue_wr : last_wr;
    next_last_idle = rising ? !(issue_rd || issue_wr) : last_idle;
    if (issue_rd || issue_wr) begin
      next_quiet = `QBSC_DRAIN;
    end else if (toggling && quiet != 4'h0) begin
      next_quiet = quiet - 4'h1;
    end
    case (state)
      QBSC_RUN: begin
        if (stop_req) begin
          next_state = QBSC_DRAINING;
        end
      end
      QBSC_DRAINING: begin
        // stop only after every burst has finished; leave on k high so k parks low
        if (quiet == 4'h0 && link.k_clk) begin
          next_state = QBSC_STOPPED;
        end
      end
      QBSC_STOPPED: begin
        if (!stop_req) begin
          next_state = QBSC_RUN;
        end
      end
      default: begin
        next_state = QBSC_RUN;
      end
    endcase
  end

  // ************************************************************
  // write beat timing, mirrors the memory side
  // ************************************************************
  // data driven so it is seen on edges four to seven
  qbsc_burst_seq #(.TW(1), .FIRST(`QBSC_WR_FIRST)) u_wr_seq (
    .sys_clk(sys_clk),
    .rst(rst),
    .ce(ce),
    .edge_hit(toggling),
    .start(issue_wr),
    .tag(slot),
    .beat_go(beat_go),
    .beat_idx(beat_idx),
    .beat_tag(beat_slot)
  );

  // ************************************************************
  // registers
  // ************************************************************
  // two data slots, since a new write may start while the last one still beats
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state <= QBSC_RUN;
      quiet <= 4'h0;
      last_rd <= 1'b0;
      last_wr <= 1'b0;
      last_idle <= 1'b1;
      slot <= 1'b0;
      dbuf <= '0;
      mbuf <= '1;
      link.k_clk <= 1'b0;
      link.c_clk <= 1'b1;
      link.c_n_clk <= 1'b1;
      link.rd_sel_n <= 1'b1;
      link.wr_sel_n <= 1'b1;
      link.addr <= '0;
      link.d <= '0;
      link.byte_mask_n <= '1;
      rd_taken <= 1'b0;
      wr_taken <= 1'b0;
      rd_data <= '0;
      rd_valid <= 1'b0;
      stopped <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      quiet <= next_quiet;
      last_rd <= next_last_rd;
      last_wr <= next_last_wr;
      last_idle <= next_last_idle;
      stopped <= (next_state == QBSC_STOPPED);
      if (issue_wr) begin
        slot <= ~slot;
        dbuf[slot] <= wr_data;
        mbuf[slot] <= wr_mask_n;
      end
      link.k_clk <= toggling ? ~link.k_clk : link.k_clk;
      // strobes tied high in single clock mode
      link.c_clk <= SINGLE_CLK ? 1'b1 : (toggling ? ~link.k_clk : link.k_clk);
      link.c_n_clk <= SINGLE_CLK ? 1'b1 : (toggling ? link.k_clk : ~link.k_clk);
      link.rd_sel_n <= rising ? ~issue_rd : link.rd_sel_n;
      link.wr_sel_n <= rising ? ~issue_wr : link.wr_sel_n;
      if (issue_rd) begin
        link.addr <= rd_addr;
      end else if (issue_wr) begin
        link.addr <= wr_addr;
      end
      if (beat_go) begin
        link.d <= (issue_wr && beat_slot == slot) ? wr_data[beat_idx] : dbuf[beat_slot][beat_idx];
        link.byte_mask_n <= mbuf[beat_slot][beat_idx];
      end
      rd_taken <= issue_rd;
      wr_taken <= issue_wr;
      rd_valid <= link.q_valid;
      if (link.q_valid) begin
        rd_data <= link.q;
      end
    end
  end
endmodule

// ===== verification/qbsc_link_props.sv
/*
  checker for the link between the two ends of the burst-of-four command port.
  assumes it sits beside the interface, fed with its signals by name.
*/
`timescale 1ns/100ps

module qbsc_link_props #(
  parameter int AW = 22
) (
  input wire logic sys_clk, // system clock
  input wire logic rst, // async reset, high
  input wire logic ce, // clock enable of both ends
  input wire logic k_clk, // input timing clock level
  input wire logic rd_sel_n, // read select
  input wire logic wr_sel_n, // write select
  input wire logic [AW-1:0] addr, // burst start address
  input wire qbsc_pkg::qbsc_word_type q, // read beat
  input wire logic q_valid // read beat new
);
  import qbsc_pkg::*;
  logic k_q;
  logic k_rise;
  logic rd_cmd;
  logic wr_cmd;
  logic [3:0] idle_cnt;
  logic [3:0] next_idle_cnt;

  // ****************
  // helper logic
  // ****************
  assign k_rise = k_clk & ~k_q;
  assign rd_cmd = k_rise & ~rd_sel_n;
  assign wr_cmd = k_rise & ~wr_sel_n;

  // sys_clk cycles since the last command, saturating so a long idle never wraps
  always_comb begin
    next_idle_cnt = idle_cnt;
    if (rd_cmd || wr_cmd) begin
      next_idle_cnt = 4'h0;
    end else if (idle_cnt != 4'hF) begin
      next_idle_cnt = idle_cnt + 4'h1;
    end
  end

  // register the helpers; reset counts as a long idle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      k_q <= 1'b0;
      idle_cnt <= 4'hF;
    end else begin
      k_q <= k_clk;
      idle_cnt <= next_idle_cnt;
    end
  end

  // ****************
  // assertions
  // ****************
  default clocking cb @(posedge sys_clk); endclocking
  // a frozen link is a legal pause, so nothing is judged while ce is low
  default disable iff (rst || !ce);

  chk_rd_spacing: assert property (rd_cmd |-> ##2 !rd_cmd)
    else $error("read issued on consecutive k rises");
  chk_wr_spacing: assert property (wr_cmd |-> ##2 !wr_cmd)
    else $error("write issued on consecutive k rises");
  chk_rd_four_beats: assert property (rd_cmd |-> ##4 q_valid [*4])
    else $error("read did not return four beats on time");
  chk_rd_beat_cause: assert property ($rose(q_valid) |-> $past(rd_cmd, 4))
    else $error("read beats without a read command");
  chk_sel_stand: assert property ($fell(k_clk) |-> $stable(rd_sel_n) && $stable(wr_sel_n)
    && $stable(addr))
    else $error("command or address moved before next k rise");
  chk_q_holds: assert property ($changed(q) |-> q_valid)
    else $error("read data changed without a beat");
  chk_stop_drained: assert property ($stable(k_clk) |-> idle_cnt >= 4'h7)
    else $error("clock stopped with a burst pending");
  chk_k_half_cycle: assert property (k_clk |=> !k_clk)
    else $error("k level held high past one cycle");

  cover property (rd_cmd);
  cover property (rd_cmd && wr_cmd);
  cover property ($stable(k_clk) && idle_cnt == 4'hF);
endmodule

// ===== verification/qbsc_tb.sv
/*
  testbench: both ends joined by one link, and a lone memory end driven by hand.
  assumes the design header, package and interface are compiled first.
*/
`timescale 1ns/100ps

module qbsc_tb;
  import qbsc_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic rd_req = 1'b0;
  logic wr_req = 1'b0;
  localparam int TAW = 8;
  logic stop_req = 1'b0;
  logic ce = 1'b1;
  logic [7:0] rd_addr = 8'h00;
  logic [7:0] wr_addr = 8'h00;
  qbsc_burst_type wr_data = '0;
  qbsc_burst_mask_type wr_mask_n = '1;
  logic rd_taken, wr_taken, rd_valid, stopped, scm, rd_drop, wr_drop, k_seen;
  qbsc_word_type rd_data;
  qbsc_burst_type w1, w2, w3, ex;
  qbsc_burst_mask_type mk;
  int failures = 0;
  int checks = 0;
  int cycles = 0;
  int rdrops = 0;
  int wdrops = 0;

  qbsc_if #(.AW(TAW)) link ();
  qbsc_if #(.AW(TAW)) link_b ();
  qbsc_ctl_end #(.AW(TAW)) u_qbsc_ctl_end (.sys_clk, .rst, .ce(ce), .link(link), .rd_req,
    .rd_addr, .wr_req, .wr_addr, .wr_data, .wr_mask_n, .stop_req, .rd_taken, .wr_taken,
    .rd_data, .rd_valid, .stopped);
  qbsc_mem_end #(.AW(TAW)) u_qbsc_mem_end (.sys_clk, .rst, .ce(ce), .link(link),
    .single_clk_mode(), .rd_dropped(), .wr_dropped());
  qbsc_mem_end #(.AW(TAW)) u_qbsc_mem_end_b (.sys_clk, .rst, .ce(ce), .link(link_b),
    .single_clk_mode(scm), .rd_dropped(rd_drop), .wr_dropped(wr_drop));
  qbsc_link_props #(.AW(TAW)) u_qbsc_link_props (.sys_clk, .rst, .ce, .k_clk(link.k_clk),
    .rd_sel_n(link.rd_sel_n), .wr_sel_n(link.wr_sel_n), .addr(link.addr), .q(link.q),
    .q_valid(link.q_valid));

  // 20 MHz clock
  initial begin
    forever #25 sys_clk = ~sys_clk;
  end

  // cycle ceiling and drop tally; a hang ends as a failure
  always @(posedge sys_clk) begin
    cycles++;
    if (rd_drop === 1'b1) rdrops++;
    if (wr_drop === 1'b1) wdrops++;
    if (cycles == 2000) begin
      failures++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic check(string name, logic [17:0] seen, logic [17:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // inputs always move 1 ns after the rising edge
  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask

  task automatic ctl_write(logic [7:0] a, qbsc_burst_type dt, qbsc_burst_mask_type m);
    int n;
    wr_addr = a;
    wr_data = dt;
    wr_mask_n = m;
    wr_req = 1'b1;
    n = 0;
    do begin
      tick();
      n++;
    end while (wr_taken !== 1'b1 && n < 20);
    wr_req = 1'b0;
    check("wr_taken", 18'(wr_taken), 18'h0_0001);
  endtask

  task automatic ctl_read(logic [7:0] a, qbsc_burst_type e);
    int n;
    int k;
    rd_addr = a;
    rd_req = 1'b1;
    n = 0;
    do begin
      tick();
      n++;
    end while (rd_taken !== 1'b1 && n < 20);
    rd_req = 1'b0;
    k = 0;
    while (k < 4 && n < 40) begin
      tick();
      n++;
      if (rd_valid === 1'b1) begin
        check("rd_data", rd_data, e[k]);
        k++;
      end
    end
    check("rd_beats", 18'(k), 18'h0_0004);
  endtask

  // hand-driven burst: command on the k rise, beats on edges four to seven
  task automatic b_burst(logic rn, logic rn2, logic wn, logic [7:0] a, qbsc_burst_type dt);
    for (int i = 0; i < 8; i++) begin
      tick();
      link_b.k_clk = ~i[0];
      link_b.rd_sel_n = (i < 2) ? rn : ((i < 4) ? rn2 : 1'b1);
      link_b.wr_sel_n = (i < 2) ? wn : 1'b1;
      link_b.addr = a;
      link_b.d = (i > 3) ? (rn ? dt[i-4] : ~dt[i-4]) : 18'h0_0000;
      link_b.byte_mask_n = (i > 3) ? 2'b00 : 2'b11;
      if (rn == 1'b0 && i > 3) begin
        check("q_valid", 18'(link_b.q_valid), 18'h0_0001);
        check("q", link_b.q, dt[i-4]);
      end
    end
  endtask

  // main sequence
  initial begin
    link_b.k_clk = 1'b0;
    link_b.c_clk = 1'b1;
    link_b.c_n_clk = 1'b1;
    link_b.rd_sel_n = 1'b1;
    link_b.wr_sel_n = 1'b1;
    link_b.addr = 8'h00;
    link_b.d = 18'h0_0000;
    link_b.byte_mask_n = 2'b11;
    mk = {2'b00, 2'b01, 2'b10, 2'b11};
    for (int i = 0; i < 4; i++) begin
      w1[i] = 18'h1_1100 + 18'(i);
      w2[i] = 18'h2_2A00 + 18'(i);
      w3[i] = 18'h3_0C50 + 18'(i);
      ex[i] = w1[i];
      if (!mk[i][0]) ex[i][8:0] = w2[i][8:0];
      if (!mk[i][1]) ex[i][17:9] = w2[i][17:9];
    end
    repeat (3) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    ctl_write(8'h10, w1, '0);
    ctl_write(8'h10, w2, mk);
    ctl_write(8'h20, w3, '0);
    ctl_read(8'h10, ex);
    ctl_read(8'h20, w3);
    stop_req = 1'b1;
    for (int n = 0; n < 40 && stopped !== 1'b1; n++) tick();
    check("stopped", 18'(stopped), 18'h0_0001);
    k_seen = link.k_clk;
    repeat (4) tick();
    check("k_still", 18'(link.k_clk), 18'(k_seen));
    stop_req = 1'b0;
    ctl_read(8'h20, w3);
    // clock enable low must hold k and every burst where it stands
    ce = 1'b0;
    k_seen = link.k_clk;
    repeat (4) tick();
    check("k_frozen", 18'(link.k_clk), 18'(k_seen));
    ce = 1'b1;
    ctl_read(8'h10, ex);
    check("single_clk", 18'(scm), 18'h0_0001);
    b_burst(1'b1, 1'b1, 1'b0, 8'h05, w1);
    b_burst(1'b0, 1'b1, 1'b1, 8'h05, w1);
    b_burst(1'b0, 1'b0, 1'b1, 8'h05, w1);
    tick();
    check("q_valid_end", 18'(link_b.q_valid), 18'h0_0000);
    check("rd_drops", 18'(rdrops), 18'h0_0001);
    b_burst(1'b0, 1'b1, 1'b0, 8'h05, w1);
    check("wr_drops", 18'(wdrops), 18'h0_0001);
    b_burst(1'b0, 1'b1, 1'b1, 8'h05, w1);
    link_b.c_clk = 1'b0;
    repeat (2) tick();
    check("single_clk_off", 18'(scm), 18'h0_0000);
    conclude();
  end
endmodule
